// ==== logic/flash_read_seq.sv ====
// serial flash command sequencer: address width switch and read commands
// assumes pins arrive asynchronously; memory array read is combinational
`timescale 1ns/1ps
`default_nettype none

module flash_read_seq #(
    parameter int ADDR_W = 25
) (
    input  wire logic                     clock_i,      // system clock
    input  wire logic                     nrst_i,       // sync reset, low
    input  wire flash_read_pkg::pins_in_s pins_i,       // select, clock, data in
    output var  flash_read_pkg::pins_out_s pins_o,      // data out and enables
    input  wire logic                     wip_i,        // write cycle running
    input  wire logic                     quad_en_i,    // quad enable bit
    input  wire logic                     ext_addr_i,   // extended address bit
    input  wire logic [1:0]               dummy_sel_i,  // dummy count field
    output logic                          wide_addr_o,  // wide address flag
    output logic                          wip_o,        // write-in-progress bit
    output logic [ADDR_W-1:0]             mem_addr_o,   // array byte address
    input  wire logic [7:0]               mem_data_i    // array byte
);
    import flash_read_pkg::*;

    if (ADDR_W < 24 || ADDR_W > 32)
    begin : g_addr_w_check
        $error("ADDR_W must lie between 24 and 32");
    end

    typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} state_e;

    // ------------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------------
    function automatic logic short_addr_op(input logic [7:0] op);
        short_addr_op = (op == OP_PARAM_TABLE || op == OP_SIGNATURE || op == OP_MAKER_ID);
    endfunction

    function automatic logic [5:0] addr_len(input logic [7:0] op, input logic wide);
        if (short_addr_op(op))
            addr_len = NARROW_ADDR_BITS;
        else
            addr_len = wide ? WIDE_ADDR_BITS : NARROW_ADDR_BITS;
    endfunction

    function automatic logic [3:0] dummy_len(input logic [7:0] op, input logic [1:0] sel);
        if (op == OP_READ)
            dummy_len = 4'h0;
        else if (op == OP_DUAL_IO)
            dummy_len = sel[DUMMY_SEL_POS] ? DUMMY_LONG : DUMMY_SHORT;
        else
            dummy_len = DUMMY_LONG;
    endfunction

    function automatic logic [ADDR_W-1:0] addr_map(input logic [31:0] raw,
                                                   input logic wide, input logic ext);
        logic [31:0] tmp;
        tmp = raw;
        if (!wide)
        begin
            tmp = {8'h00, raw[23:0]};
            tmp[EXT_ADDR_POS] = ext;
        end
        addr_map = tmp[ADDR_W-1:0];
    endfunction

    // ------------------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------------------
    pins_in_s sync1_q;
    pins_in_s sync2_q;
    logic     sclk_prev_q;
    logic     rise;
    logic     fall;
    logic     cs_hi;

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            sync1_q     <= '{cs_n: 1'b1, sclk: 1'b0, dio: 4'h0};
            sync2_q     <= '{cs_n: 1'b1, sclk: 1'b0, dio: 4'h0};
            sclk_prev_q <= 1'b0;
        end
        else
        begin
            sync1_q     <= pins_i;
            sync2_q     <= sync1_q;
            sclk_prev_q <= sync2_q.sclk;
        end
    end

    assign cs_hi = sync2_q.cs_n;
    assign rise  = !cs_hi && sync2_q.sclk && !sclk_prev_q;
    assign fall  = !cs_hi && !sync2_q.sclk && sclk_prev_q;

    // ------------------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------------------
    state_e            state_q, state_d;
    logic [7:0]        op_q, op_d;
    logic [31:0]       sh_q, sh_d;
    logic [5:0]        cnt_q, cnt_d;
    logic [5:0]        alen_q, alen_d;
    logic [3:0]        dlen_q, dlen_d;
    logic              ain2_q, ain2_d;
    logic [2:0]        olanes_q, olanes_d;
    logic              wide_q, wide_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [7:0]        osh_q, osh_d;
    logic [3:0]        obits_q, obits_d;
    logic [3:0]        dout_q, dout_d;
    logic [3:0]        doe_q, doe_d;
    logic [7:0]        cmd_byte;
    logic [1:0]        ain;
    logic [5:0]        ain_w;
    logic [31:0]       sh_next;

    assign cmd_byte = {sh_q[6:0], sync2_q.dio[0]};
    assign ain      = ain2_q ? sync2_q.dio[1:0] : {1'b0, sync2_q.dio[0]};
    assign ain_w    = ain2_q ? 6'h02 : 6'h01;
    assign sh_next  = ain2_q ? {sh_q[29:0], ain} : {sh_q[30:0], ain[0]};

    always_comb
    begin
        state_d  = state_q;
        op_d     = op_q;
        sh_d     = sh_q;
        cnt_d    = cnt_q;
        alen_d   = alen_q;
        dlen_d   = dlen_q;
        ain2_d   = ain2_q;
        olanes_d = olanes_q;
        wide_d   = wide_q;
        addr_d   = addr_q;
        osh_d    = osh_q;
        obits_d  = obits_q;
        dout_d   = dout_q;
        doe_d    = doe_q;
        if (cs_hi)
        begin
            state_d = ST_CMD;
            cnt_d   = 6'h00;
            doe_d   = 4'h0;
            obits_d = 4'h0;
        end
        else if (rise)
        begin
            case (state_q)
                ST_CMD:
                begin
                    sh_d  = {sh_q[30:0], sync2_q.dio[0]};
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q == OPCODE_LAST_BIT)
                    begin
                        op_d     = cmd_byte;
                        cnt_d    = 6'h00;
                        alen_d   = addr_len(cmd_byte, wide_q);
                        dlen_d   = dummy_len(cmd_byte, dummy_sel_i);
                        ain2_d   = (cmd_byte == OP_DUAL_IO);
                        olanes_d = 3'h1;
                        state_d  = ST_IGNORE;
                        if (cmd_byte == OP_ENTER_WIDE)
                            wide_d = 1'b1;
                        else if (cmd_byte == OP_EXIT_WIDE)
                            wide_d = 1'b0;
                        else if (cmd_byte == OP_READ)
                            state_d = ST_ADDR;
                        else if (short_addr_op(cmd_byte))
                            state_d = ST_ADDR;
                        else if (cmd_byte == OP_FAST_READ || cmd_byte == OP_DUAL_OUT
                                 || cmd_byte == OP_DUAL_IO
                                 || (cmd_byte == OP_QUAD_OUT && quad_en_i))
                        begin
                            if (!wip_i)
                                state_d = ST_ADDR;
                            if (cmd_byte == OP_DUAL_OUT || cmd_byte == OP_DUAL_IO)
                                olanes_d = 3'h2;
                            if (cmd_byte == OP_QUAD_OUT)
                                olanes_d = 3'h4;
                        end
                    end
                end
                ST_ADDR:
                begin
                    sh_d  = sh_next;
                    cnt_d = cnt_q + ain_w;
                    if (cnt_q + ain_w == alen_q)
                    begin
                        addr_d  = addr_map(sh_next, alen_q == WIDE_ADDR_BITS, ext_addr_i);
                        cnt_d   = 6'h00;
                        if (short_addr_op(op_q))
                            state_d = ST_IGNORE;
                        else
                            state_d = (dlen_q == 4'h0) ? ST_DATA : ST_DUMMY;
                    end
                end
                ST_DUMMY:
                begin
                    cnt_d = cnt_q + 6'h01;
                    if (cnt_q[3:0] + 4'h1 == dlen_q)
                        state_d = ST_DATA;
                end
                default: ;
            endcase
        end
        else if (fall && state_q == ST_DATA)
        begin
            if (obits_q == 4'h0)
            begin
                osh_d   = mem_data_i;
                addr_d  = addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
                obits_d = BYTE_BITS;
            end
            else
                osh_d = osh_q;
            case (olanes_q)
                3'h4:
                begin
                    dout_d  = osh_d[7:4];
                    doe_d   = 4'hF;
                    osh_d   = {osh_d[3:0], 4'h0};
                    obits_d = obits_d - 4'h4;
                end
                3'h2:
                begin
                    dout_d  = {2'b00, osh_d[7:6]};
                    doe_d   = 4'h3;
                    osh_d   = {osh_d[5:0], 2'b00};
                    obits_d = obits_d - 4'h2;
                end
                default:
                begin
                    dout_d  = {2'b00, osh_d[7], 1'b0};
                    doe_d   = 4'h2;
                    osh_d   = {osh_d[6:0], 1'b0};
                    obits_d = obits_d - 4'h1;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!nrst_i)
        begin
            state_q  <= ST_CMD;
            op_q     <= 8'h00;
            sh_q     <= 32'h0;
            cnt_q    <= 6'h00;
            alen_q   <= NARROW_ADDR_BITS;
            dlen_q   <= 4'h0;
            ain2_q   <= 1'b0;
            olanes_q <= 3'h1;
            wide_q   <= WIDE_RESET;
            addr_q   <= '0;
            osh_q    <= 8'h00;
            obits_q  <= 4'h0;
            dout_q   <= 4'h0;
            doe_q    <= 4'h0;
        end
        else
        begin
            state_q  <= state_d;
            op_q     <= op_d;
            sh_q     <= sh_d;
            cnt_q    <= cnt_d;
            alen_q   <= alen_d;
            dlen_q   <= dlen_d;
            ain2_q   <= ain2_d;
            olanes_q <= olanes_d;
            wide_q   <= wide_d;
            addr_q   <= addr_d;
            osh_q    <= osh_d;
            obits_q  <= obits_d;
            dout_q   <= dout_d;
            doe_q    <= doe_d;
        end
    end

    assign pins_o      = '{dio: dout_q, oe: doe_q};
    assign wide_addr_o = wide_q;
    assign wip_o       = wip_i;
    assign mem_addr_o  = addr_q;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    a_wide_enter: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (rise && state_q == ST_CMD && cnt_q == OPCODE_LAST_BIT && cmd_byte == OP_ENTER_WIDE)
        |=> wide_addr_o ##1 (alen_q == WIDE_ADDR_BITS || state_q != ST_ADDR))
        else $error("enter command did not set the wide flag");

    a_wide_exit: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (rise && state_q == ST_CMD && cnt_q == OPCODE_LAST_BIT && cmd_byte == OP_EXIT_WIDE)
        |=> !wide_addr_o)
        else $error("exit command did not clear the wide flag");

    a_wide_hold: assert property (@(posedge clock_i)
        $rose(nrst_i) |-> !wide_addr_o ##1 (!$fell(wide_q) || $past(cmd_byte) == OP_EXIT_WIDE))
        else $error("wide flag not narrow after reset");

    a_short_addr: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_q == ST_ADDR
         && (op_q == OP_PARAM_TABLE || op_q == OP_SIGNATURE || op_q == OP_MAKER_ID))
        |-> alen_q == NARROW_ADDR_BITS)
        else $error("identification read took a wide address");

    a_busy_ignore: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (rise && state_q == ST_CMD && cnt_q == OPCODE_LAST_BIT && wip_i
         && cmd_byte == OP_FAST_READ) |=> state_q == ST_IGNORE [*2])
        else $error("fast read accepted during a write cycle");

    a_plain_direct: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_q == ST_ADDR && op_q == OP_READ) |=> state_q != ST_DUMMY)
        else $error("plain read given dummy cycles");

    a_dualio_dummy: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_q == ST_DUMMY && op_q == OP_DUAL_IO)
        |-> dlen_q == (dummy_sel_i[0] ? DUMMY_LONG : DUMMY_SHORT) || $changed(dummy_sel_i))
        else $error("dual io dummy count wrong");

    a_hiz_early: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (state_q != ST_DATA) |-> doe_q == 4'h0)
        else $error("data lines driven before data phase");

    a_cs_abort: assert property (@(posedge clock_i) disable iff (!nrst_i)
        cs_hi |=> state_q == ST_CMD && cnt_q == 6'h00 && doe_q == 4'h0)
        else $error("deselect did not abort the command");

    a_addr_step: assert property (@(posedge clock_i) disable iff (!nrst_i)
        (fall && state_q == ST_DATA && obits_q == 4'h0)
        |=> addr_q == $past(addr_q) + {{(ADDR_W-1){1'b0}}, 1'b1})
        else $error("address did not step after a byte");

endmodule // flash_read_seq

`default_nettype wire

// ==== pkg/flash_read_pkg.sv ====
// constants, opcodes and pin bundles for the serial flash read sequencer
// assumes a single system clock that oversamples the serial clock pin
// ----------------------------------------------------------------------------
// How it works
// - enter command sets wide flag, 32-bit addresses
// - start narrow; leave wide on exit/reset only
// - exit command clears wide flag, 24-bit addresses
// - wide mode changes only the address length
// - table, signature, id reads keep 24 bits
// - sample on rising edge, drive on falling
// - address increments per byte, wraps to zero
// - plain read: no dummies, stream until deselect
// - fast read 0Bh: eight dummies, one line
// - busy write cycle: faster reads are ignored
// - dual output: eight dummies, out lines 1,0
// - dual io: address on two lines, 4 or 8 dummies
// - quad output: eight dummies, out lines 3..0
// - dummy field picks dual io 4 or 8
// - write-in-progress reads 1 while cycle runs
// ----------------------------------------------------------------------------
package flash_read_pkg;

    // ------------------------------------------------------------------------
    // instruction codes
    // ------------------------------------------------------------------------
    localparam logic [7:0] OP_READ        = 8'h03;
    localparam logic [7:0] OP_FAST_READ   = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT    = 8'h3B;
    localparam logic [7:0] OP_DUAL_IO     = 8'hBB;
    localparam logic [7:0] OP_QUAD_OUT    = 8'h6B;
    localparam logic [7:0] OP_ENTER_WIDE  = 8'hB7;
    localparam logic [7:0] OP_EXIT_WIDE   = 8'hE9;
    localparam logic [7:0] OP_PARAM_TABLE = 8'h5A;
    localparam logic [7:0] OP_SIGNATURE   = 8'hAB;
    localparam logic [7:0] OP_MAKER_ID    = 8'h90;

    // ------------------------------------------------------------------------
    // counts and reset values
    // ------------------------------------------------------------------------
    localparam logic [5:0] NARROW_ADDR_BITS = 6'h18;
    localparam logic [5:0] WIDE_ADDR_BITS   = 6'h20;
    localparam logic [5:0] OPCODE_LAST_BIT  = 6'h07;
    localparam logic [3:0] DUMMY_LONG       = 4'h8;
    localparam logic [3:0] DUMMY_SHORT      = 4'h4;
    localparam logic [3:0] BYTE_BITS        = 4'h8;
    localparam int         EXT_ADDR_POS     = 24;
    localparam int         DUMMY_SEL_POS    = 0;
    localparam logic       WIDE_RESET       = 1'b0;

    // ------------------------------------------------------------------------
    // pin bundles
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic       cs_n;
        logic       sclk;
        logic [3:0] dio;
    } pins_in_s;

    typedef struct packed {
        logic [3:0] dio;
        logic [3:0] oe;
    } pins_out_s;

endpackage

// ==== sim/flash_host_model.sv ====
// host controller model: select, serial clock (mode 0) and data lines
// assumes one shared system clock; the bench resolves the line levels
`timescale 1ns/1ps
`default_nettype none

module flash_host_model (
    input  wire flash_read_pkg::pins_out_s dev_i,    // device outputs
    input  wire logic                      clock_i,  // system clock
    input  wire logic [3:0]                line_i,   // resolved lines
    output var  flash_read_pkg::pins_in_s  host_o,   // select, clock, lines
    output var  logic [3:0]                oe_o      // host drives line
);
    import flash_read_pkg::*;

    logic [7:0] rx [0:7];
    logic [3:0] oe_seen;
    logic [3:0] oe_early;

    initial
    begin
        host_o = {1'b1, 1'b0, 4'h0};
        oe_o = 4'h0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask

    // one serial clock: lines change while low, then 4 clocks high
    task automatic shift(input logic [3:0] v, input logic [3:0] en);
        host_o.sclk <= 1'b0;
        host_o.dio <= v;
        oe_o <= en;
        tick(4);
        host_o.sclk <= 1'b1;
        tick(4);
    endtask

    // whole frame; data is sampled just before the next falling edge
    task automatic frame(input logic [7:0] op, input logic [31:0] addr, input int abits,
                         input int alanes, input int dummies, input int olanes,
                         input int nbytes);
        logic [31:0] a;
        logic [7:0]  b;
        a = addr << (32 - abits);
        b = 8'h00;
        oe_early = 4'h0;
        host_o.cs_n <= 1'b0;
        tick(4);
        for (int i = 7; i >= 0; i--)
            shift({3'h0, op[i]}, 4'h1);
        for (int i = 0; i < abits / alanes; i++)
        begin
            if (alanes == 2)
                shift({2'h0, a[31:30]}, 4'h3);
            else
                shift({3'h0, a[31]}, 4'h1);
            a = a << alanes;
            oe_early = oe_early | dev_i.oe;
        end
        for (int i = 0; i < dummies; i++)
        begin
            shift(4'h0, 4'h0);
            oe_early = oe_early | dev_i.oe;
        end
        for (int k = 0; k < nbytes; k++)
        begin
            for (int j = 0; j < 8 / olanes; j++)
            begin
                shift(4'h0, 4'h0);
                if (olanes == 1)
                    b = {b[6:0], line_i[1]};
                else if (olanes == 2)
                    b = {b[5:0], line_i[1:0]};
                else
                    b = {b[3:0], line_i};
            end
            rx[k] = b;
        end
        oe_seen = dev_i.oe;
        host_o.sclk <= 1'b0;
        tick(4);
        host_o.cs_n <= 1'b1;
        tick(12);
    endtask
endmodule // flash_host_model

`default_nettype wire

// ==== sim/tb_top.sv ====
// bench for the flash read sequencer, driven through a host model
// assumes flash_read_pkg, flash_read_seq and flash_host_model compiled first
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import flash_read_pkg::*;

    localparam int LIMIT = 60000;

    logic        clock_i;
    logic        nrst_i;
    logic        wip_i;
    logic        quad_en_i;
    logic        ext_addr_i;
    logic [1:0]  dummy_sel_i;
    pins_in_s    pins_i;
    pins_in_s    host_pins;
    pins_out_s   pins_o;
    logic [3:0]  host_oe;
    logic [3:0]  line;
    logic [3:0]  junk = 4'h5;
    logic        wide_addr_o;
    logic        wip_o;
    logic [24:0] mem_addr_o;
    logic [7:0]  mem_data_i;
    int          failures = 0;
    int          n_compared = 0;
    int          cycles = 0;

    function automatic logic [7:0] pattern(input logic [24:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ {a[24], 7'h00};
    endfunction

    // released lines show a toggling pattern, never the last value
    assign line = (host_oe & host_pins.dio) | (~host_oe & pins_o.oe & pins_o.dio)
                | (~host_oe & ~pins_o.oe & junk);
    assign pins_i = {host_pins.cs_n, host_pins.sclk, line};
    assign mem_data_i = pattern(mem_addr_o);

    flash_read_seq #(.ADDR_W(25)) uut (
        .clock_i     (clock_i),
        .nrst_i      (nrst_i),
        .pins_i      (pins_i),
        .pins_o      (pins_o),
        .wip_i       (wip_i),
        .quad_en_i   (quad_en_i),
        .ext_addr_i  (ext_addr_i),
        .dummy_sel_i (dummy_sel_i),
        .wide_addr_o (wide_addr_o),
        .wip_o       (wip_o),
        .mem_addr_o  (mem_addr_o),
        .mem_data_i  (mem_data_i)
    );

    flash_host_model host (
        .dev_i   (pins_o),
        .clock_i (clock_i),
        .line_i  (line),
        .host_o  (host_pins),
        .oe_o    (host_oe)
    );

    task automatic tally_and_finish;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic expect_data(input string what, input logic [24:0] a, input int n,
                               input logic [3:0] oe);
        for (int k = 0; k < n; k++)
            check(what, host.rx[k], pattern(a + 25'(k)));
        check({what, " oe"}, host.oe_seen, oe);
        check({what, " early oe"}, host.oe_early, 4'h0);
    endtask

    task automatic cfg(input logic q, input logic w, input logic e, input logic [1:0] s);
        quad_en_i <= q;
        wip_i <= w;
        ext_addr_i <= e;
        dummy_sel_i <= s;
    endtask

    task automatic t_plain_wrap;
        cfg(1'b0, 1'b0, 1'b1, 2'h0);
        host.frame(OP_READ, 32'h00FF_FFFE, 24, 1, 0, 1, 3);
        expect_data("plain wrap", 25'h1FF_FFFE, 3, 4'h2);
    endtask

    task automatic t_fixed_dummies;
        logic [7:0] ops [3] = '{OP_FAST_READ, OP_DUAL_OUT, OP_QUAD_OUT};
        logic [3:0] oes [3] = '{4'h2, 4'h3, 4'hF};
        cfg(1'b1, 1'b0, 1'b0, 2'h1);
        for (int i = 0; i < 3; i++)
        begin
            host.frame(ops[i], 32'h1230 + i, 24, 1, 8, 1 << i, 2);
            expect_data("fixed dummies", 25'h1230 + 25'(i), 2, oes[i]);
        end
    endtask

    task automatic t_dual_io;
        for (int s = 0; s < 4; s++)
        begin
            cfg(1'b0, 1'b0, 1'b0, 2'(s));
            host.frame(OP_DUAL_IO, 32'hA5C3, 24, 2, s[0] ? 8 : 4, 2, 2);
            expect_data("dual io", 25'hA5C3, 2, 4'h3);
        end
    endtask

    task automatic t_refused;
        logic [7:0] ops [4] = '{OP_FAST_READ, OP_DUAL_OUT, OP_DUAL_IO, OP_QUAD_OUT};
        cfg(1'b0, 1'b0, 1'b0, 2'h0);
        host.frame(OP_QUAD_OUT, 32'h10, 24, 1, 8, 4, 1);
        check("quad disabled oe", host.oe_seen, 4'h0);
        cfg(1'b1, 1'b1, 1'b0, 2'h0);
        @(posedge clock_i);
        check("busy flag", wip_o, 1'b1);
        for (int i = 0; i < 4; i++)
        begin
            host.frame(ops[i], 32'h20, 24, (i == 2) ? 2 : 1, 8, 1, 1);
            check("busy read oe", host.oe_seen, 4'h0);
        end
        host.frame(OP_READ, 32'h40, 24, 1, 0, 1, 2);
        expect_data("busy plain read", 25'h40, 2, 4'h2);
        cfg(1'b1, 1'b0, 1'b0, 2'h0);
        @(posedge clock_i);
        check("idle flag", wip_o, 1'b0);
    endtask

    task automatic t_wide_mode;
        logic [7:0] sops [3] = '{OP_PARAM_TABLE, OP_SIGNATURE, OP_MAKER_ID};
        host.frame(OP_ENTER_WIDE, 32'h0, 0, 1, 0, 1, 0);
        check("wide after enter", wide_addr_o, 1'b1);
        host.frame(OP_FAST_READ, 32'h0100_0040, 32, 1, 8, 1, 2);
        expect_data("wide fast", 25'h100_0040, 2, 4'h2);
        host.frame(OP_DUAL_IO, 32'h0100_0080, 32, 2, 4, 2, 1);
        expect_data("wide dual io", 25'h100_0080, 1, 4'h3);
        for (int i = 0; i < 3; i++)
        begin
            host.frame(sops[i], 32'h00AB_CD00 + i, 24, 1, 0, 1, 0);
            check("short addr", mem_addr_o, 25'h0AB_CD00 + 25'(i));
        end
        host.frame(OP_EXIT_WIDE, 32'h0, 0, 1, 0, 1, 0);
        check("wide after exit", wide_addr_o, 1'b0);
        host.frame(OP_READ, 32'h0100, 24, 1, 0, 1, 1);
        expect_data("narrow again", 25'h100, 1, 4'h2);
        host.frame(OP_ENTER_WIDE, 32'h0, 0, 1, 0, 1, 0);
        nrst_i <= 1'b0;
        repeat (6) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        check("wide after reset", wide_addr_o, 1'b0);
    endtask

    task automatic t_abort;
        host.frame(OP_READ, 32'hAB, 8, 1, 0, 1, 0);
        host.frame(OP_FAST_READ, 32'h0123, 24, 1, 8, 1, 1);
        expect_data("after abort", 25'h123, 1, 4'h2);
    endtask

    initial
    begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    always @(posedge clock_i)
    begin
        junk <= ~junk;
        cycles <= cycles + 1;
        if (cycles == LIMIT)
        begin
            failures++;
            tally_and_finish();
        end
    end

    initial
    begin
        nrst_i = 1'b0;
        cfg(1'b0, 1'b0, 1'b0, 2'h0);
        repeat (6) @(posedge clock_i);
        nrst_i <= 1'b1;
        repeat (6) @(posedge clock_i);
        check("wide at start", wide_addr_o, 1'b0);
        check("oe at start", pins_o.oe, 4'h0);
        t_plain_wrap();
        t_fixed_dummies();
        t_dual_io();
        t_refused();
        t_wide_mode();
        t_abort();
        tally_and_finish();
    end
endmodule // tb_top

`default_nettype wire
